// file: flpr_host.sv
// spi host model: mode 0 frames, link clock still between frames
// assumes clk is the core clock; half a 48 ns link period is six cycles
`timescale 1ns/1ps
module flpr_host
(
  input  wire  clk,
  output logic sck,
  output logic cs_n,
  output logic si,
  input  wire  so,
  input  wire  so_oe_n
);
  initial {sck, cs_n, si} = 3'b010;
  // half link period, moved just after a core edge
  task automatic half();
    repeat (6) @(posedge clk);
    #1;
  endtask
  // ntx bytes out msb first, then nrd bytes read back
  task automatic xfer(input logic [63:0] tx, input int ntx, input int nrd,
                      output logic [15:0] rd, output bit seen);
    rd = 16'h0;
    seen = 0;
    cs_n = 0;
    half();
    for (int i = 0; i < (ntx + nrd) * 8; i++)
    begin
      si = (i < ntx * 8) ? tx[63 - i] : ~si;
      half();
      sck = 1;
      seen |= !so_oe_n;
      if (i >= ntx * 8) rd = {rd[14:0], so};
      half();
      sck = 0;
    end
    half();
    cs_n = 1;
    si = ~si;
    half();
  endtask
endmodule // flpr_host

// file: flpr_regs.vh
// constants for the page refresh / status / configuration command slice
// assumes a 250 MHz core clock and an spi mode 0 or 3 host
`ifndef FLPR_REGS_VH
`define FLPR_REGS_VH

// opcodes
`define FLPR_OP_REFRESH_B1    8'h58
`define FLPR_OP_REFRESH_B2    8'h59
`define FLPR_OP_STATUS_RD     8'hD7
`define FLPR_OP_CONFIG_RD     8'h3F

// status byte one field positions
`define FLPR_ST1_READY        7
`define FLPR_ST1_COMPARE      6
`define FLPR_ST1_DENS_HI      5
`define FLPR_ST1_DENS_LO      2
`define FLPR_ST1_PROTECT      1
`define FLPR_ST1_PAGE_256     0
// status byte two field positions
`define FLPR_ST2_READY        7
`define FLPR_ST2_PROG_ERR     5
`define FLPR_ST2_LOCKDOWN     3
`define FLPR_ST2_PSUSP2       2
`define FLPR_ST2_PSUSP1       1
`define FLPR_ST2_ESUSP        0
// configuration register field position
`define FLPR_CFG_QUAD_EN      0

// reset values
`define FLPR_RST_COMPARE      1'b0
`define FLPR_RST_QUAD_EN      1'b0
`define FLPR_DENSITY_CODE     4'h0

// timing
`define FLPR_CLK_PERIOD_NS    4
`define FLPR_PAGE_EP_TIME_US  4000
`define FLPR_XFER_TIME_US     200

`endif

// file: flpr_sync.v
// two flip-flop synchroniser for a group of asynchronous pins
// assumes the inputs are independent levels from outside the core clock domain
`timescale 1ns/1ps
module flpr_sync
#(
  parameter W = 3
)
(
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] sync_out
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;

  // first stage feeds only the second stage
  always @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= {W{1'b1}};
      sync_ff <= {W{1'b1}};
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule // flpr_sync

// file: flpr_top.v
// command slice: page refresh / read-modify-write, status read, configuration read
// assumes spi pins are asynchronous to SYS_CLK and sck is at most a tenth of its rate
//
// Overview of operation
// RULE_01: 58h refresh buffer one, 59h buffer two
// RULE_02: copy page to buffer, then program back
// RULE_03: operation starts on chip select rising
// RULE_04: self-timed, ends within erase-program time
// RULE_05: ready flag shows busy during refresh
// RULE_06: host refreshes sector pages every 50,000 cycles
// RULE_07: data bytes turn refresh into read-modify-write
// RULE_08: D7h returns the two-byte status
// RULE_09: status holds ready, size, compare, protection, errors
// RULE_10: status read allowed at any time
// RULE_11: 3Fh returns configuration with quad enable
// RULE_12: configuration read served only when idle
// RULE_13: compare completion writes status bit six
// RULE_14: configuration holds non-volatile quad enable bit
// RULE_15: three address bytes, byte address ignored
`timescale 1ns/1ps
`include "flpr_regs.vh"
module flpr_top
#(
  parameter PAGE_EP_CYCLES = `FLPR_PAGE_EP_TIME_US * 1000 / `FLPR_CLK_PERIOD_NS,
  parameter XFER_CYCLES    = `FLPR_XFER_TIME_US * 1000 / `FLPR_CLK_PERIOD_NS
)
(
  input  wire        SYS_CLK,
  input  wire        RST,
  input  wire        SPI_SCK,
  input  wire        SPI_CS_N,
  input  wire        SPI_SI,
  output wire        SPI_SO,
  output wire        SPI_SO_OE_N,
  input  wire        CFG_PAGE_256,
  input  wire        SECT_PROTECT_ON,
  input  wire        LOCKDOWN_ON,
  input  wire        PROG_ERROR,
  input  wire        PROG_SUSP1,
  input  wire        PROG_SUSP2,
  input  wire        ERASE_SUSP,
  input  wire        OTHER_BUSY,
  input  wire        COMPARE_DONE,
  input  wire        COMPARE_MISMATCH,
  input  wire        QUAD_EN_SET,
  input  wire        QUAD_EN_CLR,
  output wire        QUAD_IO_ENABLE_BIT,
  output wire        BUSY,
  output wire [14:0] PAGE_ADDR,
  output wire        BUF_SEL,
  output wire        XFER_STB,
  output wire        XFER_MERGE,
  output wire        PROG_STB,
  output wire        BUF_WR_STB,
  output wire [7:0]  BUF_WR_DATA
);

  ////////////////////////////////////////////////////////////////////////////
  // constants
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_XFER = 3'b010;
  localparam [2:0] ST_PROG = 3'b100;
  localparam [31:0] XFER_CNT_W = XFER_CYCLES;
  localparam [31:0] PROG_CNT_W = PAGE_EP_CYCLES - XFER_CYCLES;
  localparam [23:0] XFER_CNT   = XFER_CNT_W[23:0]; // timer is 24 bits wide
  localparam [23:0] PROG_CNT   = PROG_CNT_W[23:0];

  // page number from the 24-bit address for the active page size
  function [14:0] page_of;
    input [23:0] addr;
    input        size_256;
    begin
      if (size_256)
        page_of = addr[22:8];
      else
        page_of = addr[23:9];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation and edge detection
  wire [2:0] pins_s;
  reg        sck_d_ff;
  reg        cs_n_d_ff;
  wire       sck_s  = pins_s[2];
  wire       cs_n_s = pins_s[1];
  wire       si_s   = pins_s[0];

  flpr_sync #(.W(3)) u_sync
  (
    .clk      (SYS_CLK),
    .rst      (RST),
    .async_in ({SPI_SCK, SPI_CS_N, SPI_SI}),
    .sync_out (pins_s)
  );

  // delayed copies for edges
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      sck_d_ff  <= 1'b0;
      cs_n_d_ff <= 1'b1;
    end
    else
    begin
      sck_d_ff  <= sck_s;
      cs_n_d_ff <= cs_n_s;
    end
  end

  wire sck_rise = ~cs_n_s & sck_s & ~sck_d_ff;
  wire sck_fall = ~cs_n_s & ~sck_s & sck_d_ff;
  wire cs_rise  = cs_n_s & ~cs_n_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // command shifter
  reg  [2:0]  bit_cnt_ff;
  reg  [2:0]  byte_cnt_ff;
  reg  [7:0]  rx_sr_ff;
  reg  [7:0]  opcode_ff;
  reg  [23:0] addr_ff;
  reg         data_seen_ff;
  reg         wr_stb_ff;
  reg  [7:0]  wr_data_ff;
  wire [7:0]  rx_byte   = {rx_sr_ff[6:0], si_s};
  wire        byte_done = sck_rise & (bit_cnt_ff == 3'd7);
  wire        is_refresh = (opcode_ff == `FLPR_OP_REFRESH_B1) |
                           (opcode_ff == `FLPR_OP_REFRESH_B2); // [RULE_01]

  // byte assembly, opcode, address and data bytes
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      bit_cnt_ff   <= 3'd0;
      byte_cnt_ff  <= 3'd0;
      rx_sr_ff     <= 8'h00;
      opcode_ff    <= 8'h00;
      addr_ff      <= 24'h00_0000;
      data_seen_ff <= 1'b0;
      wr_stb_ff    <= 1'b0;
      wr_data_ff   <= 8'h00;
    end
    else
    begin
      wr_stb_ff <= 1'b0;
      if (cs_n_s)
      begin
        bit_cnt_ff  <= 3'd0;
        byte_cnt_ff <= 3'd0;
        if (cs_rise)
          data_seen_ff <= 1'b0;
      end
      else if (sck_rise)
      begin
        bit_cnt_ff <= bit_cnt_ff + 3'd1;
        rx_sr_ff   <= rx_byte;
        if (byte_done)
        begin
          if (byte_cnt_ff != 3'd4)
            byte_cnt_ff <= byte_cnt_ff + 3'd1;
          if (byte_cnt_ff == 3'd0)
          begin
            opcode_ff    <= rx_byte;
            data_seen_ff <= 1'b0;
          end
          else if (byte_cnt_ff < 3'd4)
            addr_ff <= {addr_ff[15:0], rx_byte}; // [RULE_15]
          else if (is_refresh)
          begin
            data_seen_ff <= 1'b1; // [RULE_07]
            wr_stb_ff    <= 1'b1;
            wr_data_ff   <= rx_byte;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-timed refresh sequencer
  reg [2:0]  state_ff;
  reg [2:0]  nxt_state;
  reg [23:0] timer_ff;
  reg        xfer_stb_ff;
  reg        prog_stb_ff;
  reg        merge_ff;
  reg        buf_sel_ff;
  reg [14:0] page_ff;
  wire       timer_end = (timer_ff == 24'd1);
  wire       go = cs_rise & is_refresh & (byte_cnt_ff == 3'd4) & ~OTHER_BUSY;

  // next state: idle, transfer, program
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (go)
          nxt_state = ST_XFER; // [RULE_03]
      ST_XFER:
        if (timer_end)
          nxt_state = ST_PROG; // [RULE_02]
      ST_PROG:
        if (timer_end)
          nxt_state = ST_IDLE; // [RULE_04]
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  // state, timer and array strobes
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_ff    <= ST_IDLE;
      timer_ff    <= 24'd0;
      xfer_stb_ff <= 1'b0;
      prog_stb_ff <= 1'b0;
      merge_ff    <= 1'b0;
      buf_sel_ff  <= 1'b0;
      page_ff     <= 15'h0000;
    end
    else
    begin
      state_ff    <= nxt_state;
      xfer_stb_ff <= 1'b0;
      prog_stb_ff <= 1'b0;
      if (state_ff == ST_IDLE && go)
      begin
        timer_ff    <= XFER_CNT;
        xfer_stb_ff <= 1'b1; // [RULE_02]
        merge_ff    <= data_seen_ff; // [RULE_07]
        buf_sel_ff  <= opcode_ff[0]; // [RULE_01]
        page_ff     <= page_of(addr_ff, CFG_PAGE_256); // [RULE_15]
      end
      else if (state_ff == ST_XFER && timer_end)
      begin
        timer_ff    <= PROG_CNT;
        prog_stb_ff <= 1'b1; // [RULE_02]
      end
      else if (timer_ff != 24'd0)
        timer_ff <= timer_ff - 24'd1;
    end
  end

  wire busy = (state_ff != ST_IDLE) | OTHER_BUSY; // [RULE_05]

  ////////////////////////////////////////////////////////////////////////////
  // status and configuration contents
  reg compare_ff;
  reg quad_en_ff;

  // compare result and non-volatile quad enable; set wins over clear
  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      compare_ff <= `FLPR_RST_COMPARE;
      quad_en_ff <= `FLPR_RST_QUAD_EN;
    end
    else
    begin
      if (COMPARE_DONE)
        compare_ff <= COMPARE_MISMATCH; // [RULE_13]
      if (QUAD_EN_SET)
        quad_en_ff <= 1'b1; // [RULE_14]
      else if (QUAD_EN_CLR)
        quad_en_ff <= 1'b0;
    end
  end

  reg [7:0] stat1;
  reg [7:0] stat2;
  reg [7:0] cfg;

  // assemble the two status bytes and the configuration byte
  always @*
  begin
    stat1 = 8'h00;
    stat2 = 8'h00;
    cfg   = 8'h00;
    stat1[`FLPR_ST1_READY]                     = ~busy; // [RULE_09]
    stat1[`FLPR_ST1_COMPARE]                   = compare_ff;
    stat1[`FLPR_ST1_DENS_HI:`FLPR_ST1_DENS_LO] = `FLPR_DENSITY_CODE;
    stat1[`FLPR_ST1_PROTECT]                   = SECT_PROTECT_ON;
    stat1[`FLPR_ST1_PAGE_256]                  = CFG_PAGE_256;
    stat2[`FLPR_ST2_READY]                     = ~busy;
    stat2[`FLPR_ST2_PROG_ERR]                  = PROG_ERROR;
    stat2[`FLPR_ST2_LOCKDOWN]                  = LOCKDOWN_ON;
    stat2[`FLPR_ST2_PSUSP2]                    = PROG_SUSP2;
    stat2[`FLPR_ST2_PSUSP1]                    = PROG_SUSP1;
    stat2[`FLPR_ST2_ESUSP]                     = ERASE_SUSP;
    cfg[`FLPR_CFG_QUAD_EN]                     = quad_en_ff; // [RULE_11]
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial output: load on byte boundary, shift on falling sck
  reg [7:0] tx_sr_ff;
  reg       oe_n_ff;
  reg       rd_stat_ff;
  reg       stat_hi_ff;
  wire      op_now = (byte_cnt_ff == 3'd0) & byte_done;

  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      tx_sr_ff   <= 8'h00;
      oe_n_ff    <= 1'b1;
      rd_stat_ff <= 1'b0;
      stat_hi_ff <= 1'b0;
    end
    else if (cs_n_s)
    begin
      oe_n_ff    <= 1'b1;
      rd_stat_ff <= 1'b0;
    end
    else if (op_now && rx_byte == `FLPR_OP_STATUS_RD)
    begin
      tx_sr_ff   <= stat1; // [RULE_10]
      oe_n_ff    <= 1'b0; // [RULE_08]
      rd_stat_ff <= 1'b1;
      stat_hi_ff <= 1'b1;
    end
    else if (op_now && rx_byte == `FLPR_OP_CONFIG_RD && !busy)
    begin
      tx_sr_ff <= cfg; // [RULE_12]
      oe_n_ff  <= 1'b0; // [RULE_11]
    end
    else if (byte_done && !oe_n_ff)
    begin
      // status alternates its two bytes; configuration repeats
      if (rd_stat_ff)
      begin
        tx_sr_ff   <= stat_hi_ff ? stat2 : stat1; // [RULE_08]
        stat_hi_ff <= ~stat_hi_ff;
      end
      else
        tx_sr_ff <= cfg;
    end
    else if (sck_fall && bit_cnt_ff != 3'd0)
      tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign SPI_SO             = tx_sr_ff[7];
  assign SPI_SO_OE_N        = oe_n_ff;
  assign QUAD_IO_ENABLE_BIT = quad_en_ff;
  assign BUSY               = busy;
  assign PAGE_ADDR          = page_ff;
  assign BUF_SEL            = buf_sel_ff;
  assign XFER_STB           = xfer_stb_ff;
  assign XFER_MERGE         = merge_ff;
  assign PROG_STB           = prog_stb_ff;
  assign BUF_WR_STB         = wr_stb_ff;
  assign BUF_WR_DATA        = wr_data_ff;

endmodule // flpr_top

// file: flpr_top_asserts.sv
// concurrent checks on the ports of the command slice top
// assumes a bind to flpr_top with the same cycle-count parameters
`timescale 1ns/1ps
module flpr_top_chk
#(
  parameter int PAGE_EP_CYCLES = 1000,
  parameter int XFER_CYCLES    = 200
)
(
  input wire SYS_CLK,
  input wire RST,
  input wire SPI_CS_N,
  input wire SPI_SO_OE_N,
  input wire OTHER_BUSY,
  input wire QUAD_EN_SET,
  input wire QUAD_EN_CLR,
  input wire QUAD_IO_ENABLE_BIT,
  input wire BUSY,
  input wire XFER_STB,
  input wire PROG_STB,
  input wire BUF_WR_STB
);
  localparam int TAIL = PAGE_EP_CYCLES - XFER_CYCLES;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////////
  // refresh sequencing, output enable, buffer write and quad enable
  property p_xfer_prog; XFER_STB |-> ##XFER_CYCLES PROG_STB; endproperty
  a_xfer_prog: assert property (p_xfer_prog) else $error("program strobe late");
  property p_busy_run; XFER_STB |-> BUSY [*8]; endproperty
  a_busy_run: assert property (p_busy_run) else $error("busy dropped");
  property p_cs_start; XFER_STB |-> SPI_CS_N && $past(SPI_CS_N); endproperty
  a_cs_start: assert property (p_cs_start) else $error("start before cs high");
  property p_tail; PROG_STB |-> ##[1:TAIL] (!BUSY || OTHER_BUSY); endproperty
  a_tail: assert property (p_tail) else $error("refresh too long");
  property p_other; OTHER_BUSY |-> BUSY; endproperty
  a_other: assert property (p_other) else $error("busy missing");
  property p_blocked; XFER_STB |-> !$past(OTHER_BUSY); endproperty
  a_blocked: assert property (p_blocked) else $error("refresh started while busy");
  property p_oe; !SPI_SO_OE_N |-> !$past(SPI_CS_N, 6); endproperty
  a_oe: assert property (p_oe) else $error("output outside frame");
  property p_wr; BUF_WR_STB |-> !SPI_CS_N; endproperty
  a_wr: assert property (p_wr) else $error("buffer write outside frame");
  property p_qset; QUAD_EN_SET |=> QUAD_IO_ENABLE_BIT; endproperty
  a_qset: assert property (p_qset) else $error("quad set lost");
  property p_qhold; !QUAD_EN_SET && !QUAD_EN_CLR |=> $stable(QUAD_IO_ENABLE_BIT); endproperty
  a_qhold: assert property (p_qhold) else $error("quad bit moved");
endmodule // flpr_top_chk

// file: flpr_top_tb.sv
// self-checking bench for the refresh, status and configuration slice
// assumes a 250 MHz core clock and the host model driving the spi pins
`timescale 1ns/1ps
`include "flpr_regs.vh"
module flpr_top_tb;
  logic clk = 0, rst = 1, p256 = 0, prot = 0, lock = 0, perr = 0, ps1 = 0, ps2 = 0, es = 0;
  logic oth = 0, cdn = 0, cmis = 0, qset = 0, qclr = 0, qexp = 0, cexp = 0, sel, mrg;
  wire  sck, cs_n, si, so, oe_n, quad, busy, xfer, merge, prog, bwr, bsel;
  wire  [14:0] page;
  wire  [7:0]  bdat;
  logic [14:0] pg;
  logic [15:0] rd;
  logic [7:0]  wq[$];
  bit   seen;
  int   n_fail = 0, tests_run = 0, cyc = 0, n_xfer = 0, n_prog = 0, seed = 28;
  wire  so_w = oe_n ? 1'b1 : so; // released line pulled high
  flpr_top #(.PAGE_EP_CYCLES(1000), .XFER_CYCLES(200)) i_dut (.SYS_CLK(clk), .RST(rst), .SPI_SCK(sck),
    .SPI_CS_N(cs_n), .SPI_SI(si), .SPI_SO(so), .SPI_SO_OE_N(oe_n), .CFG_PAGE_256(p256), .SECT_PROTECT_ON(prot),
    .LOCKDOWN_ON(lock), .PROG_ERROR(perr), .PROG_SUSP1(ps1), .PROG_SUSP2(ps2), .ERASE_SUSP(es), .OTHER_BUSY(oth),
    .COMPARE_DONE(cdn), .COMPARE_MISMATCH(cmis), .QUAD_EN_SET(qset), .QUAD_EN_CLR(qclr), .QUAD_IO_ENABLE_BIT(quad),
    .BUSY(busy), .PAGE_ADDR(page), .BUF_SEL(bsel), .XFER_STB(xfer), .XFER_MERGE(merge), .PROG_STB(prog),
    .BUF_WR_STB(bwr), .BUF_WR_DATA(bdat));
  flpr_host i_host (.clk(clk), .sck(sck), .cs_n(cs_n), .si(si), .so(so_w), .so_oe_n(oe_n));
  initial forever #2 clk = ~clk;
  function int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [15:0] stat(input bit r);
    return {r, cexp, `FLPR_DENSITY_CODE, prot, p256, r, 1'b0, perr, 1'b0, lock, ps2, ps1, es};
  endfunction
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task cmd(input logic [7:0] op, input int nrd);
    i_host.xfer({op, 56'h0}, 1, nrd, rd, seen);
  endtask
  // one refresh frame with nd data bytes, then reads while it runs
  task refresh(input logic [7:0] op, input int nd);
    logic [23:0] a;
    a = 24'(rnd());
    p256 = a[0];
    wq.delete();
    i_host.xfer({op, a, 8'hA5, 8'h3C, 16'h0}, 4 + nd, 0, rd, seen);
    check(pg, p256 ? a[22:8] : a[23:9]);
    check({sel, mrg}, {op[0], nd > 0});
    check(wq.size(), nd);
    for (int i = 0; i < nd; i++) check(wq[i], i ? 8'h3C : 8'hA5);
    cmd(`FLPR_OP_STATUS_RD, 2);
    check(rd, stat(0));
    cmd(`FLPR_OP_CONFIG_RD, 1);
    check(seen, 0);
    for (int i = 0; i < 1200 && busy !== 1'b0; i++) @(posedge clk);
    #1 check(busy, 0);
    check(n_prog, n_xfer);
  endtask
  ////////////////////////////////////////////////////////////////
  // cycle ceiling and array strobe monitor
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_fail++;
      final_report();
    end
    if (xfer)
    begin
      n_xfer++;
      pg = page;
      sel = bsel;
      mrg = merge;
    end
    n_prog += prog;
    if (bwr) wq.push_back(bdat);
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    repeat (4) @(posedge clk);
    #1;
    repeat (4)
    begin
      {p256, prot, lock, perr, ps1, ps2, es} = 7'(rnd());
      cmd(`FLPR_OP_STATUS_RD, 2);
      check(rd, stat(1));
    end
    $display("status test done");
    for (int v = 1; v >= 0; v--)
    begin
      {cmis, cdn, cexp} = {v[0], 1'b1, v[0]};
      @(posedge clk);
      #1 cdn = 0;
      cmd(`FLPR_OP_STATUS_RD, 1);
      check(rd[6], cexp);
    end
    for (int i = 1; i < 4; i++)
    begin
      {qset, qclr} = 2'(4 - i);
      qexp = qset | (qexp & ~qclr);
      @(posedge clk);
      #1 {qset, qclr} = 2'b00;
      cmd(`FLPR_OP_CONFIG_RD, 1);
      check({quad, rd[0]}, {qexp, qexp});
    end
    $display("compare and config test done");
    // refreshing pages keeps a sector's static data alive
    refresh(`FLPR_OP_REFRESH_B1, 0);
    refresh(`FLPR_OP_REFRESH_B2, 0);
    refresh(`FLPR_OP_REFRESH_B2, 2);
    refresh(`FLPR_OP_REFRESH_B1, 1);
    i_host.xfer({`FLPR_OP_REFRESH_B1, 56'h0}, 3, 0, rd, seen);
    check({busy, 3'(n_xfer)}, 4'h4);
    $display("refresh test done");
    oth = 1;
    cmd(`FLPR_OP_STATUS_RD, 2);
    check(rd, stat(0));
    cmd(`FLPR_OP_CONFIG_RD, 1);
    check(seen, 0);
    i_host.xfer({`FLPR_OP_REFRESH_B2, 56'h0}, 4, 0, rd, seen);
    check(n_xfer, 4);
    oth = 0;
    $display("busy gating test done");
    final_report();
  end
endmodule // flpr_top_tb
bind flpr_top flpr_top_chk #(.PAGE_EP_CYCLES(PAGE_EP_CYCLES), .XFER_CYCLES(XFER_CYCLES)) i_chk (.SYS_CLK(SYS_CLK),
  .RST(RST), .SPI_CS_N(SPI_CS_N), .SPI_SO_OE_N(SPI_SO_OE_N), .OTHER_BUSY(OTHER_BUSY), .QUAD_EN_SET(QUAD_EN_SET),
  .QUAD_EN_CLR(QUAD_EN_CLR), .QUAD_IO_ENABLE_BIT(QUAD_IO_ENABLE_BIT), .BUSY(BUSY), .XFER_STB(XFER_STB),
  .PROG_STB(PROG_STB), .BUF_WR_STB(BUF_WR_STB));
